// ==== pba_map.svh ====
// register offsets, field positions, reset values and counts of the bus arbitration block
`ifndef PBA_MAP_SVH
`define PBA_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define PBA_OFF_CTRL      8'h48
`define PBA_OFF_PREEMPT   8'h4C
`define PBA_OFF_STATUS    8'h50

// ****************************************
// field positions
// ****************************************
`define PBA_CTRL_ARB_DIS  0
`define PBA_CTRL_PARK_BRG 1
`define PBA_CTRL_HI_LSB   4
`define PBA_CTRL_HI_MSB   8
`define PBA_PRE_OFF_BIT   31
`define PBA_PRE_CODE_MSB  30
`define PBA_PRE_CODE_LSB  28
`define PBA_STS_GNT_LSB   0
`define PBA_STS_OWN_LSB   8
`define PBA_STS_PREQ      12
`define PBA_STS_PARK      13
`define PBA_STS_XFER      14

// ****************************************
// reset values
// ****************************************
`define PBA_RST_ARB_DIS   1'b0
`define PBA_RST_PARK_BRG  1'b0
`define PBA_RST_HI_MASK   5'h00
`define PBA_RST_PRE_OFF   1'b0
`define PBA_RST_PRE_CODE  3'h0
`define PBA_RST_GNT       5'h01
`define PBA_RST_SYNC      10'h3FF

// ****************************************
// timing counts in bus clocks
// ****************************************
`define PBA_TIMEOUT       5'h10
`define PBA_BACKOFF       2'h2

`endif

// ==== pba_pkg.sv ====
// types shared by the bus arbitration block
package pba_pkg;

	typedef logic [7:0]  pba_addr_t;
	typedef logic [31:0] pba_word_t;

	typedef enum logic [1:0] {
		PRI_IDLE,
		PRI_PARK,
		PRI_XFER
	} pba_pri_e;

endpackage

// ==== pba_rr_pick.sv ====
// rotating pick of one requester, starting just after the last owner
`timescale 1ns/1ns

module pba_rr_pick #(
	parameter int N = 5
) (
	// requests and rotation start
	input  wire logic [N-1:0] req,
	input  wire logic [2:0]   last,
	// one-hot pick and its index
	output logic      [N-1:0] gnt,
	output logic      [2:0]   idx
);

	int   pos;
	logic found;

	// the last owner is looked at last, so it cannot starve the others
	always_comb begin
		gnt   = '0;
		idx   = last;
		found = 1'b0;
		pos   = 0;
		for (int k = 1; k <= N; k++) begin
			pos = (int'(last) + k) % N;
			if (!found && req[pos]) begin
				found    = 1'b1;
				gnt[pos] = 1'b1;
				idx      = 3'(pos);
			end
		end
	end

endmodule // pba_rr_pick

// ==== pba_arbiter.sv ====
// primary request/park logic and secondary bus arbiter of the bridge
`timescale 1ns/1ns
`include "pba_map.svh"

// Summary of operation
// - request held while upstream work is queued
// - drop request for two clocks after retry/abort
// - request only once transaction fully queued
// - start transaction the clock after grant
// - park primary only granted, idle, not requesting
// - park address and command first, parity later
// - grant lost while parked: release next clock
// - parked with work: start if granted before
// - arbiter serves four externals plus bridge
// - internal arbiter can be disabled
// - two-level rotating priority picks next master
// - withdraw grant after sixteen idle unused cycles
// - idle bus: one clock gap between grants
// - busy bus: grant may move same clock
// - preemption switch in 4Ch, on after reset
// - preempt delay 0..64 clocks, zero at reset
// - waiting master preempts owner after delay
// - bus stays parked at last owner
// - after reset the bridge holds the grant
// - 48h bit 1 parks bus at bridge
module pba_arbiter (
	// clock and reset
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	// register port
	input  wire pba_pkg::pba_addr_t REG_ADDR,
	input  wire pba_pkg::pba_word_t REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output pba_pkg::pba_word_t     REG_RDATA,
	// upstream queue and primary master datapath
	input  wire logic              UPQ_READY,
	input  wire logic              PRI_DONE,
	input  wire logic              PRI_BACKOFF,
	output logic                   PRI_START,
	// primary bus pins
	input  wire logic              P_GNT_N,
	input  wire logic              P_FRAME_N,
	input  wire logic              P_IRDY_N,
	output logic                   P_REQ_N,
	output logic                   PRIMARY_AD_OE,
	output logic                   PRIMARY_CMD_BYTE_EN_OE,
	output logic                   PRIMARY_PARITY_OE,
	// secondary bus pins
	input  wire logic [3:0]        S_REQ_N,
	input  wire logic              S_FRAME_N,
	input  wire logic              SECONDARY_INITIATOR_READY_N,
	input  wire logic              S_EXT_GNT_N,
	output logic [3:0]             S_GNT_N,
	output logic                   S_GNT_OE,
	output logic                   S_EXT_REQ_N,
	// bridge secondary master
	input  wire logic              BRG_SEC_REQ,
	output logic                   BRG_SEC_GNT
);
	import pba_pkg::*;

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [9:0] sync1_r;
	logic [9:0] sync2_r;
	wire  [9:0] pins_w = {S_EXT_GNT_N, SECONDARY_INITIATOR_READY_N, S_FRAME_N, S_REQ_N, P_IRDY_N, P_FRAME_N, P_GNT_N};

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sync1_r <= `PBA_RST_SYNC;
			sync2_r <= `PBA_RST_SYNC;
		end else begin
			sync1_r <= pins_w;
			sync2_r <= sync1_r;
		end
	end

	wire       gnt_p_w   = ~sync2_r[0];
	wire       pidle_w   = sync2_r[1] & sync2_r[2];
	wire [3:0] sreq_w    = ~sync2_r[6:3];
	wire       bus_busy_w = ~sync2_r[7] | ~sync2_r[8];
	wire       ext_gnt_w = ~sync2_r[9];

	// ****************************************
	// configuration registers
	// ****************************************
	logic       arb_dis_r;
	logic       park_brg_r;
	logic [4:0] hi_mask_r;
	logic       pre_off_r;
	logic [2:0] pre_code_r;

	wire wr_ctrl_w = REG_WR && (REG_ADDR == `PBA_OFF_CTRL);
	wire wr_pre_w  = REG_WR && (REG_ADDR == `PBA_OFF_PREEMPT);

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			arb_dis_r  <= `PBA_RST_ARB_DIS;
			park_brg_r <= `PBA_RST_PARK_BRG;
			hi_mask_r  <= `PBA_RST_HI_MASK;
			pre_off_r  <= `PBA_RST_PRE_OFF;
			pre_code_r <= `PBA_RST_PRE_CODE;
		end else begin
			if (wr_ctrl_w) begin
				arb_dis_r  <= REG_WDATA[`PBA_CTRL_ARB_DIS];
				park_brg_r <= REG_WDATA[`PBA_CTRL_PARK_BRG];
				hi_mask_r  <= REG_WDATA[`PBA_CTRL_HI_MSB:`PBA_CTRL_HI_LSB];
			end
			if (wr_pre_w) begin
				pre_off_r  <= REG_WDATA[`PBA_PRE_OFF_BIT];
				pre_code_r <= REG_WDATA[`PBA_PRE_CODE_MSB:`PBA_PRE_CODE_LSB];
			end
		end
	end

	// ****************************************
	// primary request and parking
	// ****************************************
	pba_pri_e   pri_state_r;
	pba_pri_e   pri_state_nxt;
	logic [1:0] bo_cnt_r;
	logic       pri_start_r;
	logic       p_req_n_r;
	logic       ad_oe_r;
	logic       par_oe_r;

	wire       can_go_w = UPQ_READY && (bo_cnt_r == 2'h0) && (pri_state_r != PRI_XFER);
	// parked start needs no fresh request edge, only the grant seen last clock
	wire       start_w  = gnt_p_w && pidle_w && can_go_w && (!p_req_n_r || pri_state_r == PRI_PARK);
	wire       park_w   = gnt_p_w && p_req_n_r && pidle_w;
	wire [1:0] bo_cnt_nxt = PRI_BACKOFF ? `PBA_BACKOFF :
	                        (bo_cnt_r != 2'h0) ? (bo_cnt_r - 2'h1) : 2'h0;
	wire       req_n_nxt = ~(UPQ_READY && (bo_cnt_nxt == 2'h0));

	always_comb begin
		pri_state_nxt = pri_state_r;
		case (pri_state_r)
			PRI_IDLE, PRI_PARK: begin
				if (start_w)
					pri_state_nxt = PRI_XFER;
				else if (park_w)
					pri_state_nxt = PRI_PARK;
				else
					pri_state_nxt = PRI_IDLE;
			end
			PRI_XFER: begin
				if (PRI_DONE || PRI_BACKOFF)
					pri_state_nxt = PRI_IDLE;
			end
			default: pri_state_nxt = PRI_IDLE;
		endcase
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pri_state_r <= PRI_IDLE;
			bo_cnt_r    <= 2'h0;
			pri_start_r <= 1'b0;
			p_req_n_r   <= 1'b1;
			ad_oe_r     <= 1'b0;
			par_oe_r    <= 1'b0;
		end else begin
			pri_state_r <= pri_state_nxt;
			bo_cnt_r    <= bo_cnt_nxt;
			pri_start_r <= start_w;
			p_req_n_r   <= req_n_nxt;
			ad_oe_r     <= (pri_state_nxt == PRI_PARK);
			// parity joins one clock after address and command lines
			par_oe_r    <= (pri_state_nxt == PRI_PARK) && (pri_state_r == PRI_PARK);
		end
	end

	// ****************************************
	// secondary arbiter
	// ****************************************
	logic [4:0] gnt_r;
	logic [4:0] gnt_nxt;
	logic [2:0] owner_r;
	logic [4:0] to_cnt_r;
	logic [6:0] wait_cnt_r;
	logic [3:0] s_gnt_n_r;
	logic       s_gnt_oe_r;
	logic       s_ext_req_n_r;
	logic       brg_gnt_r;
	logic [4:0] pick_hi_w;
	logic [4:0] pick_lo_w;
	logic [2:0] idx_hi_w;
	logic [2:0] idx_lo_w;

	wire [4:0] reqs_w      = {sreq_w, BRG_SEC_REQ};
	wire [4:0] hi_req_w    = reqs_w & hi_mask_r;
	wire [4:0] lo_req_w    = reqs_w & ~hi_mask_r;
	wire       any_req_w   = |reqs_w;
	wire       gnt_any_w   = |gnt_r;
	wire [4:0] others_w    = reqs_w & ~gnt_r;
	wire       any_other_w = |others_w;
	wire       owner_req_w = |(reqs_w & gnt_r);
	wire [6:0] delay_w     = (pre_code_r == 3'h0) ? 7'h00 : (7'h01 << (pre_code_r - 3'h1));
	wire       preempt_w   = ~pre_off_r && any_other_w && (wait_cnt_r >= delay_w);
	wire       release_w   = any_other_w && ~owner_req_w;
	wire       drop_w      = gnt_any_w && (preempt_w || release_w);
	// fires on the edge that closes the sixteenth unused cycle, so the grant stands sixteen cycles only
	wire       timeout_w   = gnt_any_w && owner_req_w && ~bus_busy_w && (to_cnt_r == `PBA_TIMEOUT - 5'h01);
	wire       park_move_w = gnt_any_w && ~any_req_w && park_brg_r && ~gnt_r[0];
	wire [2:0] idle_idx_w  = park_brg_r ? 3'h0 : owner_r;
	wire [4:0] idle_gnt_w  = 5'h01 << idle_idx_w;
	wire [4:0] pick_w      = (|hi_req_w) ? pick_hi_w : pick_lo_w;
	wire [2:0] pick_idx_w  = (|hi_req_w) ? idx_hi_w : idx_lo_w;
	wire [4:0] tgt_w       = any_req_w ? pick_w : idle_gnt_w;
	wire [2:0] tgt_idx_w   = any_req_w ? pick_idx_w : idle_idx_w;

	pba_rr_pick #(.N(5)) u_pick_hi (
		.req  (hi_req_w),
		.last (owner_r),
		.gnt  (pick_hi_w),
		.idx  (idx_hi_w)
	);

	pba_rr_pick #(.N(5)) u_pick_lo (
		.req  (lo_req_w),
		.last (owner_r),
		.gnt  (pick_lo_w),
		.idx  (idx_lo_w)
	);

	// grants change only through tgt_w or all-off, so one-hot holds by construction
	always_comb begin
		gnt_nxt = gnt_r;
		if (arb_dis_r)
			gnt_nxt = 5'h00;
		else if (timeout_w)
			gnt_nxt = 5'h00;
		else if (~gnt_any_w || drop_w || park_move_w) begin
			if (gnt_any_w && ~bus_busy_w && (tgt_w != gnt_r))
				gnt_nxt = 5'h00;
			else
				gnt_nxt = tgt_w;
		end
	end

	wire       gnt_keep_w   = (gnt_nxt == gnt_r);
	wire [2:0] owner_nxt    = (~gnt_keep_w && (gnt_nxt != 5'h00)) ? tgt_idx_w : owner_r;
	wire [4:0] to_cnt_nxt   = (gnt_any_w && owner_req_w && ~bus_busy_w && gnt_keep_w) ? (to_cnt_r + 5'h01) : 5'h00;
	wire [6:0] wait_cnt_nxt = (gnt_any_w && any_other_w && ~drop_w) ?
	                          ((wait_cnt_r == 7'h7F) ? wait_cnt_r : (wait_cnt_r + 7'h01)) : 7'h00;

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			gnt_r         <= `PBA_RST_GNT;
			owner_r       <= 3'h0;
			to_cnt_r      <= 5'h00;
			wait_cnt_r    <= 7'h00;
			s_gnt_n_r     <= 4'hF;
			s_gnt_oe_r    <= 1'b1;
			s_ext_req_n_r <= 1'b1;
			brg_gnt_r     <= 1'b1;
		end else begin
			gnt_r         <= gnt_nxt;
			owner_r       <= owner_nxt;
			to_cnt_r      <= to_cnt_nxt;
			wait_cnt_r    <= wait_cnt_nxt;
			s_gnt_n_r     <= ~gnt_nxt[4:1];
			s_gnt_oe_r    <= ~arb_dis_r;
			s_ext_req_n_r <= arb_dis_r ? ~BRG_SEC_REQ : 1'b1;
			brg_gnt_r     <= arb_dis_r ? ext_gnt_w : gnt_nxt[0];
		end
	end

	// ****************************************
	// register read port
	// ****************************************
	pba_word_t ctrl_rd_w;
	pba_word_t pre_rd_w;
	pba_word_t sts_rd_w;
	pba_word_t rdata_r;

	always_comb begin
		ctrl_rd_w = '0;
		pre_rd_w  = '0;
		sts_rd_w  = '0;
		ctrl_rd_w[`PBA_CTRL_ARB_DIS]                  = arb_dis_r;
		ctrl_rd_w[`PBA_CTRL_PARK_BRG]                 = park_brg_r;
		ctrl_rd_w[`PBA_CTRL_HI_MSB:`PBA_CTRL_HI_LSB]  = hi_mask_r;
		pre_rd_w[`PBA_PRE_OFF_BIT]                    = pre_off_r;
		pre_rd_w[`PBA_PRE_CODE_MSB:`PBA_PRE_CODE_LSB] = pre_code_r;
		sts_rd_w[`PBA_STS_GNT_LSB +: 5]               = gnt_r;
		sts_rd_w[`PBA_STS_OWN_LSB +: 3]               = owner_r;
		sts_rd_w[`PBA_STS_PREQ]                       = ~p_req_n_r;
		sts_rd_w[`PBA_STS_PARK]                       = (pri_state_r == PRI_PARK);
		sts_rd_w[`PBA_STS_XFER]                       = (pri_state_r == PRI_XFER);
	end

	wire pba_word_t rd_mux_w = (REG_ADDR == `PBA_OFF_CTRL)    ? ctrl_rd_w :
	                           (REG_ADDR == `PBA_OFF_PREEMPT) ? pre_rd_w  :
	                           (REG_ADDR == `PBA_OFF_STATUS)  ? sts_rd_w  : '0;

	// data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			rdata_r <= '0;
		else
			rdata_r <= REG_RD ? rd_mux_w : '0;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign REG_RDATA              = rdata_r;
	assign PRI_START              = pri_start_r;
	assign P_REQ_N                = p_req_n_r;
	assign PRIMARY_AD_OE          = ad_oe_r;
	assign PRIMARY_CMD_BYTE_EN_OE = ad_oe_r;
	assign PRIMARY_PARITY_OE      = par_oe_r;
	assign S_GNT_N                = s_gnt_n_r;
	assign S_GNT_OE               = s_gnt_oe_r;
	assign S_EXT_REQ_N            = s_ext_req_n_r;
	assign BRG_SEC_GNT            = brg_gnt_r;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_req_held: assert property (UPQ_READY && bo_cnt_r == 2'h0 && !PRI_BACKOFF |=> !P_REQ_N)
		else $error("primary request not held with queued work");
	a_backoff_drop: assert property (PRI_BACKOFF |=> P_REQ_N [*2])
		else $error("primary request not dropped for two clocks");
	a_req_queued: assert property (!UPQ_READY |=> P_REQ_N)
		else $error("primary request without a queued transaction");
	a_start_grant: assert property (gnt_p_w && !P_REQ_N && pidle_w && can_go_w |=> PRI_START)
		else $error("no start the clock after grant");
	a_park_cond: assert property (PRIMARY_AD_OE |-> $past(gnt_p_w && P_REQ_N && pidle_w))
		else $error("primary parked without grant, idle bus or with request");
	a_park_parity: assert property ($rose(PRIMARY_AD_OE) |-> !PRIMARY_PARITY_OE ##1 (PRIMARY_PARITY_OE || !PRIMARY_AD_OE))
		else $error("parity not one clock behind address when parking");
	a_park_release: assert property (PRIMARY_AD_OE && !gnt_p_w |=> !PRIMARY_AD_OE && !PRIMARY_PARITY_OE)
		else $error("parked lines kept after grant loss");
	a_parked_start: assert property (pri_state_r == PRI_PARK && gnt_p_w && pidle_w && can_go_w |=> PRI_START)
		else $error("parked bridge did not start");
	a_arb_off: assert property (arb_dis_r |=> S_GNT_N == 4'hF && !S_GNT_OE)
		else $error("grants driven while internal arbiter disabled");
	a_grant_timeout: assert property (to_cnt_r == `PBA_TIMEOUT - 5'h01 && owner_req_w && !bus_busy_w |=> gnt_r == 5'h00)
		else $error("unused grant not withdrawn after sixteen clocks");
	a_idle_gap: assert property (!bus_busy_w && gnt_r != 5'h00 |=> gnt_r == 5'h00 || gnt_r == $past(gnt_r))
		else $error("grant moved on idle bus without a gap");
	a_preempt_move: assert property (!arb_dis_r && !timeout_w && gnt_any_w && preempt_w |=> gnt_r != $past(gnt_r))
		else $error("owner not preempted after delay");
	a_park_last: assert property (!arb_dis_r && gnt_any_w && !any_other_w && !park_brg_r && !timeout_w
		|=> gnt_r == $past(gnt_r))
		else $error("parked grant moved with no new request");
	a_park_bridge: assert property (!arb_dis_r && !any_req_w && park_brg_r && gnt_r == 5'h00 |=> gnt_r == 5'h01)
		else $error("idle bus not parked at bridge");
	a_gnt_onehot: assert property ($onehot0(gnt_r) && $onehot0(~S_GNT_N))
		else $error("more than one secondary grant");

	c_pri_start:   cover property (PRI_START);
	c_pri_park:    cover property (PRIMARY_PARITY_OE);
	c_timeout:     cover property (timeout_w);
	c_busy_switch: cover property (bus_busy_w && gnt_any_w ##1 gnt_any_w && gnt_r != $past(gnt_r));

endmodule // pba_arbiter

// ==== pba_far_end.sv ====
// far-end model: primary arbiter with datapath stand-in, and four secondary masters
`timescale 1ns/1ns

module pba_far_end (
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       SYS_RST,
	// bench controls
	input  wire logic       PARK_GNT,
	input  wire logic [2:0] GNT_LAT,
	input  wire logic [3:0] WANT,
	input  wire logic [3:0] USE_BUS,
	// primary bus
	input  wire logic       P_REQ_N,
	input  wire logic       PRI_START,
	output logic            P_GNT_N,
	output logic            P_FRAME_N,
	output logic            P_IRDY_N,
	// secondary bus
	input  wire logic [3:0] S_GNT_N,
	input  wire logic       S_EXT_REQ_N,
	output logic [3:0]      S_REQ_N,
	output logic            S_FRAME_N,
	output logic            SECONDARY_INITIATOR_READY_N_N,
	output logic            S_EXT_GNT_N
);
	// ****************************************
	// far-end state
	// ****************************************
	logic [2:0] wait_r;
	logic [1:0] pfr_r;
	logic [2:0] sfr_r;
	logic [3:0] done_r;
	logic       s_busy;

	// released control lines sit on pull-ups, so an idle bus reads high
	assign s_busy    = (sfr_r != 3'h0);
	assign S_FRAME_N = ~s_busy;
	assign SECONDARY_INITIATOR_READY_N_N  = ~s_busy;
	assign P_FRAME_N = (pfr_r == 2'h0);
	assign P_IRDY_N  = (pfr_r == 2'h0);
	assign S_REQ_N   = ~(WANT & ~done_r);

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wait_r      <= 3'h0;
			pfr_r       <= 2'h0;
			sfr_r       <= 3'h0;
			done_r      <= 4'h0;
			P_GNT_N     <= 1'b1;
			S_EXT_GNT_N <= 1'b1;
		end else begin
			// slow arbiter: grant only after GNT_LAT clocks of request, unless parking
			wait_r      <= P_REQ_N ? 3'h0 : (wait_r == GNT_LAT ? wait_r : wait_r + 3'h1);
			P_GNT_N     <= ~(PARK_GNT || (!P_REQ_N && wait_r == GNT_LAT));
			pfr_r       <= PRI_START ? 2'h3 : (pfr_r == 2'h0 ? 2'h0 : pfr_r - 2'h1);
			S_EXT_GNT_N <= S_EXT_REQ_N;
			sfr_r       <= s_busy ? sfr_r - 3'h1 : 3'h0;
			done_r      <= done_r & WANT;
			for (int i = 0; i < 4; i++) begin
				// one transfer per request, then the master drops it
				if (!s_busy && !S_GNT_N[i] && !S_REQ_N[i] && USE_BUS[i]) begin
					sfr_r     <= 3'h4;
					done_r[i] <= 1'b1;
				end
			end
		end
	end
endmodule // pba_far_end

// ==== tb_pba_arbiter.sv ====
// self-checking bench of the bus arbitration block
`timescale 1ns/1ns

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch at %0t: got 0x%0h exp 0x%0h", $time, (g), (e)); end end
`define WAITF(c, n) begin #1; w = 0; while (!(c) && w < (n)) begin @(posedge CLK); #1; w++; end \
	`CHK(w < (n), 1'b1) end
`define COUNT(c) begin w = 0; while ((c) && w < 40) begin w++; tick(1); end end

module tb_pba_arbiter;
	import pba_pkg::*;

	// ****************************************
	// signals
	// ****************************************
	logic       CLK, SYS_RST, REG_WR, REG_RD, UPQ_READY, PRI_DONE, PRI_BACKOFF, PRI_START;
	logic       P_GNT_N, P_FRAME_N, P_IRDY_N, P_REQ_N, PRIMARY_AD_OE, PRIMARY_CMD_BYTE_EN_OE;
	logic       PRIMARY_PARITY_OE, S_FRAME_N, SECONDARY_INITIATOR_READY_N, S_EXT_GNT_N;
	logic       S_GNT_OE, S_EXT_REQ_N, BRG_SEC_REQ, BRG_SEC_GNT, PARK_GNT;
	logic [3:0] S_REQ_N, S_GNT_N, WANT, USE_BUS;
	logic [2:0] GNT_LAT;
	pba_addr_t  REG_ADDR;
	pba_word_t  REG_WDATA, REG_RDATA;
	int         w, n_fail, samples_checked;
	int         pri_order[3] = '{2, 0, 1};

	pba_arbiter DUT (.CLK, .SYS_RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
		.UPQ_READY, .PRI_DONE, .PRI_BACKOFF, .PRI_START, .P_GNT_N, .P_FRAME_N, .P_IRDY_N,
		.P_REQ_N, .PRIMARY_AD_OE, .PRIMARY_CMD_BYTE_EN_OE, .PRIMARY_PARITY_OE, .S_REQ_N,
		.S_FRAME_N, .SECONDARY_INITIATOR_READY_N, .S_EXT_GNT_N, .S_GNT_N, .S_GNT_OE,
		.S_EXT_REQ_N, .BRG_SEC_REQ, .BRG_SEC_GNT);

	pba_far_end far (.CLK, .SYS_RST, .PARK_GNT, .GNT_LAT, .WANT, .USE_BUS, .P_REQ_N, .PRI_START,
		.P_GNT_N, .P_FRAME_N, .P_IRDY_N, .S_GNT_N, .S_EXT_REQ_N, .S_REQ_N, .S_FRAME_N,
		.SECONDARY_INITIATOR_READY_N_N(SECONDARY_INITIATOR_READY_N), .S_EXT_GNT_N);

	always #10 CLK = ~CLK;

	// ****************************************
	// bus tasks and verdict
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask

	task automatic wr(input pba_addr_t a, input pba_word_t d);
		@(posedge CLK);
		REG_ADDR  <= a;
		REG_WDATA <= d;
		REG_WR    <= 1'b1;
		@(posedge CLK);
		REG_WR    <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input pba_addr_t a, input pba_word_t e);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_RD   <= 1'b1;
		@(posedge CLK);
		REG_RD   <= 1'b0;
		#1;
		`CHK(REG_RDATA, e)
	endtask

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// the whole run needs well under a thousand clocks
	initial begin
		repeat (5000) @(posedge CLK);
		n_fail++;
		wrap_up();
	end

	initial begin
		CLK             = 1'b0;
		SYS_RST         = 1'b1;
		REG_ADDR        = 8'h00;
		REG_WDATA       = 32'h0;
		REG_WR          = 1'b0;
		REG_RD          = 1'b0;
		UPQ_READY       = 1'b0;
		PRI_DONE        = 1'b0;
		PRI_BACKOFF     = 1'b0;
		BRG_SEC_REQ     = 1'b0;
		PARK_GNT        = 1'b0;
		GNT_LAT         = 3'h3;
		WANT            = 4'h0;
		USE_BUS         = 4'hF;
		n_fail          = 0;
		samples_checked = 0;
		repeat (4) @(posedge CLK);
		SYS_RST <= 1'b0;
		tick(1);
		`CHK(BRG_SEC_GNT, 1'b1)
		`CHK(S_GNT_N, 4'hF)
		`CHK(P_REQ_N, 1'b1)
		rd(8'h50, 32'h00000001);
		rd(8'h48, 32'h00000000);
		rd(8'h4C, 32'h00000000);
		wr(8'h44, 32'hFFFFFFFF);
		rd(8'h44, 32'h00000000);
		wr(8'h50, 32'hFFFFFFFF);
		rd(8'h50, 32'h00000001);
		wr(8'h4C, 32'hF0000000);
		rd(8'h4C, 32'hF0000000);
		wr(8'h48, 32'h000001F2);
		rd(8'h48, 32'h000001F2);
		wr(8'h48, 32'h00000000);
		// primary request, backoff and normal end
		@(posedge CLK) UPQ_READY <= 1'b1;
		tick(1);
		`CHK(P_REQ_N, 1'b0)
		`WAITF(PRI_START, 20)
		@(posedge CLK) PRI_BACKOFF <= 1'b1;
		@(posedge CLK) PRI_BACKOFF <= 1'b0;
		#1;
		`COUNT(P_REQ_N)
		`CHK(w, 2)
		`WAITF(PRI_START, 20)
		@(posedge CLK) PRI_DONE <= 1'b1;
		UPQ_READY <= 1'b0;
		@(posedge CLK) PRI_DONE <= 1'b0;
		tick(1);
		`CHK(P_REQ_N, 1'b1)
		// primary parking, start from park, release
		@(posedge CLK) PARK_GNT <= 1'b1;
		`WAITF(PRIMARY_AD_OE, 10)
		`CHK(PRIMARY_CMD_BYTE_EN_OE, 1'b1)
		`CHK(PRIMARY_PARITY_OE, 1'b0)
		tick(1);
		`CHK(PRIMARY_PARITY_OE, 1'b1)
		@(posedge CLK) UPQ_READY <= 1'b1;
		`WAITF(PRI_START, 10)
		@(posedge CLK) PRI_DONE <= 1'b1;
		UPQ_READY <= 1'b0;
		@(posedge CLK) PRI_DONE <= 1'b0;
		`WAITF(PRIMARY_PARITY_OE, 10)
		@(posedge CLK) PARK_GNT <= 1'b0;
		`WAITF(!PRIMARY_AD_OE, 6)
		`CHK(PRIMARY_PARITY_OE, 1'b0)
		// preemption off so each master starts its transfer before handing over
		wr(8'h4C, 32'h80000000);
		@(posedge CLK) WANT <= 4'hF;
		`WAITF(!BRG_SEC_GNT, 10)
		`CHK(S_GNT_N, 4'hF)
		for (int i = 0; i < 4; i++) begin
			`WAITF(S_GNT_N == 4'(~(4'h1 << i)), 30)
		end
		tick(8);
		`CHK(S_GNT_N, 4'h7)
		rd(8'h50, 32'h00000410);
		@(posedge CLK) WANT <= 4'h0;
		wr(8'h48, 32'h00000080);
		@(posedge CLK) WANT <= 4'h7;
		foreach (pri_order[k]) begin
			`WAITF(S_GNT_N == 4'(~(4'h1 << pri_order[k])), 30)
		end
		// a master that never starts loses its grant
		@(posedge CLK) USE_BUS <= 4'h0;
		WANT <= 4'h8;
		`WAITF(S_GNT_N == 4'h7, 20)
		`COUNT(S_GNT_N == 4'h7)
		`CHK(w, 16)
		// preemption on with no delay: a waiting master takes the bus from a requesting owner
		wr(8'h4C, 32'h00000000);
		@(posedge CLK) WANT <= 4'h9;
		`WAITF(S_GNT_N == 4'hE, 8)
		@(posedge CLK) WANT <= 4'h0;
		wr(8'h48, 32'h00000002);
		`WAITF(BRG_SEC_GNT, 10)
		`CHK(S_GNT_N, 4'hF)
		wr(8'h48, 32'h00000001);
		tick(4);
		`CHK(S_GNT_OE, 1'b0)
		`CHK(BRG_SEC_GNT, 1'b0)
		@(posedge CLK) BRG_SEC_REQ <= 1'b1;
		`WAITF(BRG_SEC_GNT, 10)
		`CHK(S_EXT_REQ_N, 1'b0)
		wrap_up();
	end
endmodule // tb_pba_arbiter
